// ==== rms_pkg.sv ====
// Constants and types for the receiver mode sequencer
package rms_pkg;
	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_HZ        = 200_000_000;
	localparam int TICK_HZ       = 615_000;
	localparam int TICK_CYC      = CLK_HZ / TICK_HZ;
	localparam int SPI_BAUD      = 310_000;
	localparam int SPI_HALF_CYC  = CLK_HZ / (2 * SPI_BAUD);
	localparam int LEAD_TIMEOUT  = 66;
	localparam int CFG_LOW_TICKS = 2;

	// ----------------------------------------
	// Synchroniser lanes
	// ----------------------------------------
	localparam int SY_W    = 7;
	localparam int SY_MODE = 0;
	localparam int SY_RUN  = 1;
	localparam int SY_SUP  = 2;
	localparam int SY_WAKE = 3;
	localparam int SY_DDAT = 4;
	localparam int SY_DCLK = 5;
	localparam int SY_EOT  = 6;

	// Sleep-to-run ratios
	localparam logic [4:0] RATIO_0 = 5'h03;
	localparam logic [4:0] RATIO_1 = 5'h07;
	localparam logic [4:0] RATIO_2 = 5'h0F;
	localparam logic [4:0] RATIO_3 = 5'h1F;

	localparam logic [7:0] LEAD_WORD_DEF = 8'h00;
	localparam int         FIFO_DEPTH    = 2;

	typedef enum logic [3:0] {
		ST_POR        = 4'h0,
		ST_CONFIG     = 4'h1,
		ST_OSC_SLEEP  = 4'h2,
		ST_OSC_LISTEN = 4'h3,
		ST_OSC_LEAD   = 4'h4,
		ST_OSC_DATA   = 4'h5,
		ST_PIN_SLEEP  = 4'h6,
		ST_PIN_LISTEN = 4'h7,
		ST_PIN_ID     = 4'h8,
		ST_PIN_LEAD   = 4'h9,
		ST_PIN_DATA   = 4'hA,
		ST_PIN_RAW    = 4'hB,
		ST_GO_SLEEP   = 4'hC
	} rms_state_t;
endpackage

// ==== rms_sequencer.sv ====
// Operating-mode sequencer of a strobed telegram receiver
`timescale 1ns/1ps

// Notes on behaviour
// - Sleep: all off, or only wake oscillator
// - Config: SPI slave, receiver on, raw out
// - State moves only on sample tick
// - Config to sleep under three ticks
// - Power-on clear gives initial state
// - Stay in config while mode select low
// - Mode select low over one tick forces config
// - Oscillator sleep keeps oscillator and counter
// - Listen: match advances, else sleep at period
// - Lead wait timeout of 66 wake periods
// - Output data and clock, inverted if complement
// - Oscillator machine: sleep entry two ticks
// - Enable low selects pin-controlled sleep
// - Run request enters listen, match advances
// - Send match byte at 310 kBd
// - Run request low returns to sleep
// - Pin lead wait: lead word advances
// - Data output finishes byte before sleep
// - After telegram end, raw bits without clock
// - Pin machine: sleep entry two ticks
// - Supply-level run request forces run, no discharge
// - Wake ratio 3, 7, 15 or 31 periods
// - Match byte compared against received word
// - Final partial byte padded
// - Lead check only with packet manager
module rms_sequencer #(
	parameter logic [7:0] LEAD_WORD = rms_pkg::LEAD_WORD_DEF
) (
	input  wire logic                    REF_CLK_IN,
	input  wire logic                    RESET_IN,
	input  wire logic                    MODE_SELECT_N_IN,
	input  wire logic                    RUN_REQUEST_IN,
	input  wire logic                    RUN_AT_SUPPLY_IN,
	input  wire logic                    WAKE_OSC_IN,
	input  wire logic                    DEMOD_DATA_IN,
	input  wire logic                    DEMOD_CLK_IN,
	input  wire logic                    END_OF_TELEGRAM_IN,
	input  wire logic                    WAKE_OSC_ENABLE_IN,
	input  wire logic [1:0]              WAKE_RATIO_IN,
	input  wire logic                    PACKET_MANAGER_ENABLE_IN,
	input  wire logic                    LEAD_WORD_PRESENT_IN,
	input  wire logic [7:0]              MATCH_BYTE_IN,
	output logic      [3:0]              STATE_OUT,
	output logic                         RECEIVER_ON_OUT,
	output logic                         WAKE_OSC_ON_OUT,
	output logic                         OSC_DISCHARGE_EN_OUT,
	output logic                         SPI_SLAVE_OUT,
	output logic                         RAW_DEMOD_OUT,
	output logic                         MOSI_OUT,
	output logic                         MOSI_OE_OUT,
	output logic                         SCLK_OUT,
	output logic                         SCLK_OE_OUT
);
	import rms_pkg::*;

	// ----------------------------------------
	// State record
	// ----------------------------------------
	typedef struct packed {
		rms_state_t      st;
		rms_state_t      tgt;
		logic [9:0]      div;
		logic [1:0]      lowcnt;
		logic [SY_W-1:0] sy1;
		logic [SY_W-1:0] sy2;
		logic [SY_W-1:0] sy3;
		logic [7:0]      sh;
		logic [6:0]      wcnt;
		logic            match_ev;
		logic            lead_ev;
		logic            lead_inv;
		logic            eot_ev;
		logic            stop;
		logic [7:0]      abyte;
		logic [2:0]      acnt;
		logic            afull;
		logic [1:0][7:0] fifo;
		logic            wp;
		logic            rp;
		logic [1:0]      fcnt;
		logic [7:0]      sbyte;
		logic [2:0]      scnt;
		logic            sbusy;
		logic [9:0]      sdiv;
		logic            sclk;
		logic            smosi;
		logic            rx_on;
		logic            osc_on;
		logic            dis_en;
		logic            slave;
		logic            raw;
		logic            mosi;
		logic            mosi_oe;
		logic            sclk_oe;
	} rms_reg_t;

	localparam logic [9:0] TICK_LAST = 10'(TICK_CYC - 1);
	localparam logic [9:0] HALF_LAST = 10'(SPI_HALF_CYC - 1);
	localparam logic [6:0] TMO_W     = 7'(LEAD_TIMEOUT);
	localparam logic [1:0] LOW_W     = 2'(CFG_LOW_TICKS);
	localparam logic [1:0] FDEPTH_W  = 2'(FIFO_DEPTH);

	rms_reg_t r_reg;
	rms_reg_t r_next;

	// Wake periods of sleep for a ratio code
	function automatic logic [6:0] ratio_of(input logic [1:0] sel);
		case (sel)
			2'h0:    ratio_of = {2'h0, RATIO_0};
			2'h1:    ratio_of = {2'h0, RATIO_1};
			2'h2:    ratio_of = {2'h0, RATIO_2};
			default: ratio_of = {2'h0, RATIO_3};
		endcase
	endfunction

	// Word or its complement
	function automatic logic word_hit(input logic [7:0] w, input logic [7:0] ref_w);
		word_hit = (w == ref_w) || (w == ~ref_w);
	endfunction

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		rms_reg_t        n;
		logic            tick;
		logic [SY_W-1:0] rise;
		logic            run_req;
		logic            need_lead;
		logic            goslp;
		logic            push;
		logic            pop;
		logic            drained;
		logic            osc_st;
		logic            run_st;
		logic            dat_st;
		logic            master;
		logic [7:0]      nsh;
		n = r_reg;
		goslp = 1'b0;
		pop = 1'b0;

		// Divider for the sample tick
		tick = (r_reg.div == TICK_LAST);
		n.div = tick ? '0 : r_reg.div + 10'h001;

		// Two-stage pin synchronisers, edges seen on the second stage only
		n.sy1 = {END_OF_TELEGRAM_IN, DEMOD_CLK_IN, DEMOD_DATA_IN, WAKE_OSC_IN,
			RUN_AT_SUPPLY_IN, RUN_REQUEST_IN, MODE_SELECT_N_IN};
		n.sy2 = r_reg.sy1;
		n.sy3 = r_reg.sy2;
		rise = r_reg.sy2 & ~r_reg.sy3;
		run_req = r_reg.sy2[SY_RUN] | r_reg.sy2[SY_SUP];
		need_lead = PACKET_MANAGER_ENABLE_IN & LEAD_WORD_PRESENT_IN;
		osc_st = (r_reg.st >= ST_OSC_LISTEN) && (r_reg.st <= ST_OSC_DATA);
		dat_st = (r_reg.st == ST_OSC_DATA) || (r_reg.st == ST_PIN_DATA);
		drained = !r_reg.sbusy && (r_reg.fcnt == 2'h0) && !r_reg.afull;
		nsh = {r_reg.sh[6:0], r_reg.sy2[SY_DDAT]};

		// State transitions, taken only on a tick
		if (tick) begin
			n.match_ev = 1'b0;
			n.lead_ev = 1'b0;
			n.eot_ev = 1'b0;
			case (r_reg.st)
				ST_POR:    goslp = 1'b1;
				ST_CONFIG: goslp = r_reg.sy2[SY_MODE];
				ST_GO_SLEEP: begin
					n.st = r_reg.tgt;
					n.fcnt = '0;
					n.afull = 1'b0;
					n.acnt = '0;
					n.stop = 1'b0;
					n.lead_inv = 1'b0;
				end
				ST_OSC_SLEEP: begin
					if (!WAKE_OSC_ENABLE_IN) begin
						goslp = 1'b1;
					end else if (run_req || r_reg.wcnt >= ratio_of(WAKE_RATIO_IN)) begin
						n.st = ST_OSC_LISTEN;
					end
				end
				ST_OSC_LISTEN: begin
					if (r_reg.match_ev) begin
						n.st = need_lead ? ST_OSC_LEAD : ST_OSC_DATA;
					end else if (r_reg.wcnt != 7'h00 && !run_req) begin
						goslp = 1'b1;
					end
				end
				ST_OSC_LEAD: begin
					if (r_reg.lead_ev) begin
						n.st = ST_OSC_DATA;
					end else if (r_reg.wcnt >= TMO_W) begin
						goslp = 1'b1;
					end
				end
				ST_OSC_DATA: begin
					if (r_reg.eot_ev) begin
						n.stop = 1'b1;
					end
					// The last full or padded byte drains before the sleep entry
					goslp = r_reg.stop && drained;
				end
				ST_PIN_SLEEP: begin
					if (WAKE_OSC_ENABLE_IN) begin
						goslp = 1'b1;
					end else if (run_req) begin
						n.st = ST_PIN_LISTEN;
					end
				end
				ST_PIN_LISTEN: begin
					if (!run_req) begin
						goslp = 1'b1;
					end else if (r_reg.match_ev) begin
						n.st = ST_PIN_ID;
						n.abyte = MATCH_BYTE_IN;
						n.afull = 1'b1;
					end
				end
				ST_PIN_ID: begin
					if (!run_req) begin
						goslp = 1'b1;
					end else if (drained) begin
						n.st = need_lead ? ST_PIN_LEAD : ST_PIN_DATA;
					end
				end
				ST_PIN_LEAD: begin
					if (!run_req) begin
						goslp = 1'b1;
					end else if (r_reg.lead_ev) begin
						n.st = ST_PIN_DATA;
					end
				end
				ST_PIN_DATA: begin
					// A dropped request waits for the byte in flight
					if (!run_req) begin
						n.stop = 1'b1;
					end
					if (r_reg.stop && drained) begin
						goslp = 1'b1;
					end else if (r_reg.eot_ev && drained) begin
						n.st = ST_PIN_RAW;
					end
				end
				ST_PIN_RAW: goslp = !run_req;
				default:    goslp = 1'b1;
			endcase
			if (osc_st && !WAKE_OSC_ENABLE_IN) begin
				goslp = 1'b1;
			end
			if (goslp) begin
				n.st = ST_GO_SLEEP;
				n.tgt = WAKE_OSC_ENABLE_IN ? ST_OSC_SLEEP : ST_PIN_SLEEP;
			end
			// Mode select sampled per tick; two low samples exceed one tick
			n.lowcnt = r_reg.sy2[SY_MODE] ? 2'h0 :
				(r_reg.lowcnt == LOW_W) ? LOW_W : r_reg.lowcnt + 2'h1;
			if (n.lowcnt == LOW_W) begin
				n.st = ST_CONFIG;
			end
		end

		// Wake period counter, restarted on every state change
		if (n.st != r_reg.st) begin
			n.wcnt = '0;
		end else if (rise[SY_WAKE] && r_reg.wcnt != 7'h7F) begin
			n.wcnt = r_reg.wcnt + 7'h01;
		end

		// Word detection on recovered clock edges; set wins over tick clear
		if (rise[SY_DCLK]) begin
			n.sh = nsh;
			if (r_reg.st == ST_OSC_LISTEN || r_reg.st == ST_PIN_LISTEN) begin
				n.match_ev = n.match_ev | word_hit(nsh, MATCH_BYTE_IN);
			end
			if ((r_reg.st == ST_OSC_LEAD || r_reg.st == ST_PIN_LEAD) && word_hit(nsh, LEAD_WORD)) begin
				n.lead_ev = 1'b1;
				n.lead_inv = (nsh != LEAD_WORD);
			end
		end
		if (rise[SY_EOT] && dat_st) begin
			n.eot_ev = 1'b1;
			// Pad a partial byte; a full boundary sends nothing extra
			if (r_reg.acnt != 3'h0 && !r_reg.afull) begin
				n.abyte = r_reg.abyte << (3'h0 - r_reg.acnt);
				n.afull = 1'b1;
				n.acnt = '0;
			end
		end

		// Byte assembly; a full holding byte stalls further bits
		if (rise[SY_DCLK] && dat_st && PACKET_MANAGER_ENABLE_IN && !r_reg.stop &&
			!r_reg.eot_ev && !r_reg.afull) begin
			n.abyte = {r_reg.abyte[6:0], r_reg.sy2[SY_DDAT] ^ r_reg.lead_inv};
			n.acnt = r_reg.acnt + 3'h1;
			n.afull = (r_reg.acnt == 3'h7);
		end

		// Serializer: shift on rising SCLK, peer samples on falling
		if (r_reg.sbusy) begin
			n.sdiv = r_reg.sdiv + 10'h001;
			if (r_reg.sdiv == HALF_LAST) begin
				n.sdiv = '0;
				n.sclk = !r_reg.sclk;
				if (!r_reg.sclk) begin
					n.smosi = r_reg.sbyte[7];
				end else begin
					n.sbyte = {r_reg.sbyte[6:0], 1'b0};
					n.scnt = r_reg.scnt + 3'h1;
					n.sbusy = (r_reg.scnt != 3'h7);
					n.smosi = 1'b0;
				end
			end
		end else if (r_reg.fcnt != 2'h0) begin
			pop = 1'b1;
			n.sbyte = r_reg.fifo[r_reg.rp];
			n.rp = !r_reg.rp;
			n.sbusy = 1'b1;
			n.sdiv = '0;
			n.scnt = '0;
		end

		// Two-entry buffer between assembly and serializer
		push = r_reg.afull && (r_reg.fcnt != FDEPTH_W);
		if (push) begin
			n.fifo[r_reg.wp] = r_reg.abyte;
			n.wp = !r_reg.wp;
			n.afull = 1'b0;
			n.acnt = '0;
		end
		n.fcnt = (n.st == ST_GO_SLEEP) ? '0 : r_reg.fcnt + {1'b0, push} - {1'b0, pop};

		// Registered outputs follow the state
		run_st = (r_reg.st >= ST_OSC_LISTEN && r_reg.st <= ST_OSC_DATA) ||
			(r_reg.st >= ST_PIN_LISTEN && r_reg.st <= ST_PIN_RAW);
		master = run_st && r_reg.st != ST_PIN_RAW &&
			(PACKET_MANAGER_ENABLE_IN || r_reg.st == ST_PIN_ID);
		n.rx_on = run_st || r_reg.st == ST_CONFIG || r_reg.st == ST_POR;
		n.osc_on = (r_reg.st == ST_OSC_SLEEP) || osc_st;
		n.dis_en = n.osc_on && !r_reg.sy2[SY_SUP];
		n.slave = (r_reg.st == ST_CONFIG);
		n.raw = n.rx_on && r_reg.sy2[SY_DDAT];
		n.mosi_oe = run_st;
		n.sclk_oe = master;
		n.mosi = master ? r_reg.smosi : (run_st && r_reg.sy2[SY_DDAT]);
		n.sclk = master ? n.sclk : 1'b0;
		r_next = n;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge REF_CLK_IN) begin
		if (RESET_IN) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	// Outputs straight from the record
	assign STATE_OUT            = r_reg.st;
	assign RECEIVER_ON_OUT      = r_reg.rx_on;
	assign WAKE_OSC_ON_OUT      = r_reg.osc_on;
	assign OSC_DISCHARGE_EN_OUT = r_reg.dis_en;
	assign SPI_SLAVE_OUT        = r_reg.slave;
	assign RAW_DEMOD_OUT        = r_reg.raw;
	assign MOSI_OUT             = r_reg.mosi;
	assign MOSI_OE_OUT          = r_reg.mosi_oe;
	assign SCLK_OUT             = r_reg.sclk;
	assign SCLK_OE_OUT          = r_reg.sclk_oe;
endmodule

// ==== rms_monitor.sv ====
// Port-level checker for the receiver mode sequencer
`timescale 1ns/1ps
module rms_monitor (
	input wire logic       REF_CLK_IN,
	input wire logic       RESET_IN,
	input wire logic       MODE_SELECT_N_IN,
	input wire logic       RUN_REQUEST_IN,
	input wire logic       RUN_AT_SUPPLY_IN,
	input wire logic [3:0] STATE_OUT,
	input wire logic       RECEIVER_ON_OUT,
	input wire logic       WAKE_OSC_ON_OUT,
	input wire logic       OSC_DISCHARGE_EN_OUT,
	input wire logic       SPI_SLAVE_OUT,
	input wire logic       MOSI_OUT,
	input wire logic       SCLK_OUT
);
	logic [3:0] prev_reg;
	logic [9:0] gap_reg;
	logic [9:0] low_reg;

	// ----------------------------------------
	// Helper counters
	// ----------------------------------------
	// Saturating, so a long quiet stretch never wraps into a false short gap
	always_ff @(posedge REF_CLK_IN) begin
		prev_reg <= STATE_OUT;
		gap_reg  <= (RESET_IN || STATE_OUT != prev_reg) ? 10'h000 :
			((gap_reg == 10'h3FF) ? gap_reg : gap_reg + 10'h001);
		low_reg  <= (RESET_IN || MODE_SELECT_N_IN) ? 10'h000 :
			((low_reg == 10'h3E8) ? low_reg : low_reg + 10'h001);
	end

	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (RESET_IN);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	tick_grid_a: assert property (STATE_OUT != prev_reg |-> gap_reg >= 10'h140)
		else $error("state moved off the tick grid");
	config_force_a: assert property (low_reg == 10'h3E8 |-> STATE_OUT == 4'h1)
		else $error("long mode select low did not force config");
	config_stay_a: assert property (
		(STATE_OUT == 4'h1 && !MODE_SELECT_N_IN) [*6] |=> STATE_OUT == 4'h1)
		else $error("config left while mode select low");
	config_ports_a: assert property (
		STATE_OUT == 4'h1 && $past(STATE_OUT) == 4'h1 |-> SPI_SLAVE_OUT && RECEIVER_ON_OUT)
		else $error("config without slave port or receiver");
	config_exit_a: assert property (
		$past(STATE_OUT) == 4'h1 && STATE_OUT == 4'hC
		|-> ##[1:330] (STATE_OUT == 4'h2 || STATE_OUT == 4'h6))
		else $error("config exit too slow");
	pin_sleep_a: assert property (
		STATE_OUT == 4'h6 && $past(STATE_OUT) == 4'h6
		|-> !RECEIVER_ON_OUT && !WAKE_OSC_ON_OUT && !SCLK_OUT && !MOSI_OUT)
		else $error("pin sleep not fully powered down");
	osc_sleep_a: assert property (
		STATE_OUT == 4'h2 && $past(STATE_OUT) == 4'h2 |-> WAKE_OSC_ON_OUT && !RECEIVER_ON_OUT)
		else $error("oscillator sleep power wrong");
	discharge_off_a: assert property (RUN_AT_SUPPLY_IN [*6] |=> !OSC_DISCHARGE_EN_OUT)
		else $error("discharge path on at supply run");
	run_drop_a: assert property (
		(STATE_OUT inside {4'h7, 4'h8, 4'h9, 4'hB} && !RUN_REQUEST_IN && !RUN_AT_SUPPLY_IN)
		[*8] |-> ##[1:340] STATE_OUT == 4'hC)
		else $error("run request drop ignored");
	sleep_entry_a: assert property (STATE_OUT == 4'hC |-> ##[0:330] STATE_OUT != 4'hC)
		else $error("stuck on the way to sleep");
endmodule

// ==== rms_spi_peer.sv ====
// Controller-side SPI peer that collects bytes shifted out by the sequencer
`timescale 1ns/1ps
module rms_spi_peer (
	input  wire logic       rst_in,
	input  wire logic       sclk_in,
	input  wire logic       sclk_oe_in,
	input  wire logic       mosi_in,
	input  wire logic       mosi_oe_in,
	output logic      [7:0] byte_out,
	output logic      [7:0] count_out
);
	logic [7:0] shift_reg;
	logic [2:0] bit_reg;

	// Capture on falling clock, MSB first; only while both lines are driven,
	// since a released line carries nothing worth keeping.
	// Never clocks a config transfer, since the sequencer keeps its clock enable low in config.
	always_ff @(negedge sclk_in or posedge rst_in) begin
		if (rst_in) begin
			shift_reg <= 8'h00;
			bit_reg   <= 3'h0;
			byte_out  <= 8'h00;
			count_out <= 8'h00;
		end else if (sclk_oe_in && mosi_oe_in) begin
			shift_reg <= {shift_reg[6:0], mosi_in};
			bit_reg   <= bit_reg + 3'h1;
			if (bit_reg == 3'h7) begin
				byte_out  <= {shift_reg[6:0], mosi_in};
				count_out <= count_out + 8'h01;
			end
		end
	end
endmodule

// ==== rms_sequencer_tb_top.sv ====
// Self-checking bench for the receiver mode sequencer
`timescale 1ns/1ps
module rms_sequencer_tb_top;
	import rms_pkg::*;
	logic       clk = 1'b0;
	logic       rst, msel_n, run, sup, wake, ddat, dclk, eot, osc_en, pme, lead, wake_run;
	logic [1:0] ratio;
	logic [7:0] match, rx_byte, rx_cnt;
	logic [3:0] state;
	logic       rx_on, osc_on, dis_en, slave, raw, mosi, mosi_oe, sclk, sclk_oe;
	int         error_cnt = 0;
	int         samples_checked = 0;

	// Reference clock, 5 ns period
	always #2.5 clk = ~clk;

	rms_sequencer u_rms_sequencer (
		.REF_CLK_IN(clk), .RESET_IN(rst), .MODE_SELECT_N_IN(msel_n), .RUN_REQUEST_IN(run),
		.RUN_AT_SUPPLY_IN(sup), .WAKE_OSC_IN(wake), .DEMOD_DATA_IN(ddat), .DEMOD_CLK_IN(dclk),
		.END_OF_TELEGRAM_IN(eot), .WAKE_OSC_ENABLE_IN(osc_en), .WAKE_RATIO_IN(ratio),
		.PACKET_MANAGER_ENABLE_IN(pme), .LEAD_WORD_PRESENT_IN(lead), .MATCH_BYTE_IN(match),
		.STATE_OUT(state), .RECEIVER_ON_OUT(rx_on), .WAKE_OSC_ON_OUT(osc_on),
		.OSC_DISCHARGE_EN_OUT(dis_en), .SPI_SLAVE_OUT(slave), .RAW_DEMOD_OUT(raw),
		.MOSI_OUT(mosi), .MOSI_OE_OUT(mosi_oe), .SCLK_OUT(sclk), .SCLK_OE_OUT(sclk_oe));

	rms_spi_peer u_rms_spi_peer (.rst_in(rst), .sclk_in(sclk), .sclk_oe_in(sclk_oe),
		.mosi_in(mosi), .mosi_oe_in(mosi_oe), .byte_out(rx_byte), .count_out(rx_cnt));

	// Wake oscillator: one rising edge every two ticks while enabled
	always begin
		repeat (TICK_CYC) @(posedge clk);
		wake <= wake_run & ~wake;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n * TICK_CYC) @(negedge clk);
	endtask

	// Bounded wait for a state code, then compare
	task automatic wait_state(input logic [3:0] s, input int ticks);
		int n;
		n = 0;
		while (state !== s && n < ticks * TICK_CYC) begin
			@(negedge clk);
			n++;
		end
		check("state", {4'h0, s}, {4'h0, state});
	endtask

	// Link clock is free of the reference clock; it stands still between bytes
	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			ddat <= b[i];
			#24 dclk <= 1'b1;
			#24 dclk <= 1'b0;
		end
		ddat <= ~b[0];
	endtask

	task automatic wait_byte(input logic [7:0] exp);
		logic [7:0] c0;
		int         n;
		c0 = rx_cnt;
		n  = 0;
		while (rx_cnt === c0 && n < 8000) begin
			@(negedge clk);
			n++;
		end
		check("spi byte", exp, rx_byte);
	endtask

	task automatic done(input int n);
		$display("test %0d finished", n);
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Watchdog above the whole sequence, yet inside the cycle budget
	initial begin
		repeat (95000) @(posedge clk);
		error_cnt++;
		$display("ERROR watchdog expected finish seen timeout");
		print_verdict();
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		{run, sup, wake, ddat, dclk, eot, osc_en, lead, wake_run} = '0;
		{rst, msel_n, pme, ratio, match} = {3'b111, 2'h0, 8'hA5};
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check("state", 8'h00, {4'h0, state});
		wait_state(4'h6, 4);
		check("rx on", 8'h00, {7'h00, rx_on});
		done(1);
		@(posedge clk) msel_n <= 1'b0;
		wait_state(4'h1, 4);
		@(posedge clk) ddat <= 1'b1;
		tick(3);
		check("slave", 8'h01, {7'h00, slave});
		check("raw", 8'h01, {7'h00, raw});
		@(posedge clk) ddat <= 1'b0;
		check("state", 8'h01, {4'h0, state});
		@(posedge clk) msel_n <= 1'b1;
		wait_state(4'h6, 3);
		done(2);
		@(posedge clk) run <= 1'b1;
		wait_state(4'h7, 2);
		send_byte(8'h12);
		tick(2);
		check("state", 8'h07, {4'h0, state});
		send_byte(8'hA5);
		wait_state(4'h8, 2);
		wait_byte(8'hA5);
		wait_state(4'hA, 2);
		send_byte(8'h3C);
		wait_byte(8'h3C);
		@(posedge clk) eot <= 1'b1;
		wait_state(4'hB, 2);
		@(posedge clk) eot <= 1'b0;
		tick(1);
		check("raw mosi", {7'h00, ddat}, {7'h00, mosi});
		check("sclk oe", 8'h00, {7'h00, sclk_oe});
		@(posedge clk) run <= 1'b0;
		wait_state(4'hC, 2);
		wait_state(4'h6, 2);
		done(3);
		@(posedge clk) begin
			lead <= 1'b1;
			run  <= 1'b1;
		end
		wait_state(4'h7, 2);
		send_byte(8'h5A);
		wait_state(4'h8, 2);
		wait_byte(8'hA5);
		wait_state(4'h9, 2);
		send_byte(~LEAD_WORD_DEF);
		wait_state(4'hA, 2);
		send_byte(8'h3C);
		tick(4);
		@(posedge clk) run <= 1'b0;
		tick(1);
		check("state", 8'h0A, {4'h0, state});
		wait_byte(8'hC3);
		wait_state(4'h6, 6);
		done(4);
		@(posedge clk) begin
			osc_en   <= 1'b1;
			wake_run <= 1'b1;
		end
		wait_state(4'h2, 4);
		@(negedge clk);
		check("osc on", 8'h01, {7'h00, osc_on});
		check("rx on", 8'h00, {7'h00, rx_on});
		tick(1);
		check("state", 8'h02, {4'h0, state});
		wait_state(4'h3, 10);
		wait_state(4'h2, 8);
		done(5);
		@(posedge clk) sup <= 1'b1;
		wait_state(4'h3, 4);
		check("discharge", 8'h00, {7'h00, dis_en});
		@(posedge clk) sup <= 1'b0;
		wait_state(4'h2, 8);
		done(6);
		wait_state(4'h3, 12);
		send_byte(8'hA5);
		wait_state(4'h4, 2);
		tick(128);
		check("state", 8'h04, {4'h0, state});
		wait_state(4'h2, 12);
		done(7);
		print_verdict();
	end
endmodule

bind rms_sequencer rms_monitor u_rms_monitor (.REF_CLK_IN(REF_CLK_IN), .RESET_IN(RESET_IN),
	.MODE_SELECT_N_IN(MODE_SELECT_N_IN), .RUN_REQUEST_IN(RUN_REQUEST_IN),
	.RUN_AT_SUPPLY_IN(RUN_AT_SUPPLY_IN), .STATE_OUT(STATE_OUT),
	.RECEIVER_ON_OUT(RECEIVER_ON_OUT), .WAKE_OSC_ON_OUT(WAKE_OSC_ON_OUT),
	.OSC_DISCHARGE_EN_OUT(OSC_DISCHARGE_EN_OUT), .SPI_SLAVE_OUT(SPI_SLAVE_OUT),
	.MOSI_OUT(MOSI_OUT), .SCLK_OUT(SCLK_OUT));
